// *** inc/doag_defs.vh ***
// Constants for the dual operand address generator
`ifndef DOAG_DEFS_VH
`define DOAG_DEFS_VH
`define DOAG_AW      14
`define DOAG_DW      16
`define DOAG_PW      24
`define DOAG_XW      8
`define DOAG_NPTR    4
`define DOAG_SELW    2
`define DOAG_XBYTE_RST 8'h00
`define DOAG_PTR_RST 14'h0000
// Register-load target codes
`define DOAG_TGT_PTR 2'h0
`define DOAG_TGT_MOD 2'h1
`define DOAG_TGT_LEN 2'h2
`define DOAG_TGT_BASE 2'h3
`endif

// *** src/doag_top.v ***
// Dual operand address generator with program memory word adapter
`timescale 1ns/1ps
`include "doag_defs.vh"
module doag_top (
	input  wire                  core_clk,
	input  wire                  reset_n,
	input  wire                  dataOnlyAcc,
	input  wire [`DOAG_SELW-1:0] dataOnlyPtr,
	input  wire [`DOAG_SELW-1:0] dataOnlyMod,
	input  wire                  bitRevMode,
	input  wire                  dualSpaceAcc,
	input  wire [`DOAG_SELW-1:0] dualSpacePtr,
	input  wire [`DOAG_SELW-1:0] dualSpaceMod,
	input  wire                  dualSpaceToPm,
	input  wire                  sportAcc,
	input  wire [`DOAG_SELW-1:0] sportPtr,
	input  wire [`DOAG_SELW-1:0] sportMod,
	input  wire                  ldEn,
	input  wire                  ldUnit,
	input  wire [1:0]            ldTgt,
	input  wire [`DOAG_SELW-1:0] ldIdx,
	input  wire [`DOAG_AW-1:0]   ldVal,
	input  wire                  xbyteWrEn,
	input  wire [`DOAG_XW-1:0]   xbyteWrVal,
	input  wire                  pmWrReq,
	input  wire [`DOAG_DW-1:0]   pmWrReg,
	input  wire                  pmRdData,
	input  wire [`DOAG_PW-1:0]   pmRdWord,
	output wire                  sportStall,
	output wire [`DOAG_AW-1:0]   dmAddr,
	output wire                  dmAddrValid,
	output wire [`DOAG_AW-1:0]   dsAddr,
	output wire                  dsAddrValid,
	output reg                   dsIsPm,
	output reg  [`DOAG_PW-1:0]   pmWrWord,
	output reg                   pmWrValid,
	output reg  [`DOAG_DW-1:0]   pmRdReg,
	output reg  [`DOAG_XW-1:0]   word_extension_byte
);
	// Serial port transfers borrow the dual space unit when the core leaves it idle;
	// the core keeps priority so instruction timing stays fixed
	wire useSport = sportAcc && !dualSpaceAcc;
	wire dsAcc    = dualSpaceAcc || useSport;
	wire [`DOAG_SELW-1:0] dsPtr = useSport ? sportPtr : dualSpacePtr;
	wire [`DOAG_SELW-1:0] dsMod = useSport ? sportMod : dualSpaceMod;
	assign sportStall = sportAcc && dualSpaceAcc;

	// Both units run in parallel; each steps only in cycles its access enable is high
	doag_unit #(.BITREV_OK(1)) data_only_address_unit (
		.core_clk  (core_clk),
		.reset_n   (reset_n),
		.accEn     (dataOnlyAcc),
		.accPtr    (dataOnlyPtr),
		.accMod    (dataOnlyMod),
		.bitRevEn  (bitRevMode),
		.ldEn      (ldEn && !ldUnit),
		.ldTgt     (ldTgt),
		.ldIdx     (ldIdx),
		.ldVal     (ldVal),
		.addrOut   (dmAddr),
		.addrValid (dmAddrValid)
	);
	doag_unit #(.BITREV_OK(0)) dual_space_address_unit (
		.core_clk  (core_clk),
		.reset_n   (reset_n),
		.accEn     (dsAcc),
		.accPtr    (dsPtr),
		.accMod    (dsMod),
		.bitRevEn  (1'b0),
		.ldEn      (ldEn && ldUnit),
		.ldTgt     (ldTgt),
		.ldIdx     (ldIdx),
		.ldVal     (ldVal),
		.addrOut   (dsAddr),
		.addrValid (dsAddrValid)
	);

	always @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			dsIsPm              <= 1'b0;
			pmWrWord            <= {`DOAG_PW{1'b0}};
			pmWrValid           <= 1'b0;
			pmRdReg             <= {`DOAG_DW{1'b0}};
			word_extension_byte <= `DOAG_XBYTE_RST;
		end
		else
		begin
			if (dsAcc)
				dsIsPm <= dualSpaceToPm && !useSport;
			pmWrValid <= pmWrReq;
			if (pmWrReq)
				pmWrWord <= {pmWrReg, word_extension_byte};
			if (pmRdData)
			begin
				pmRdReg             <= pmRdWord[`DOAG_PW-1:`DOAG_XW];
				word_extension_byte <= pmRdWord[`DOAG_XW-1:0];
			end
			else if (xbyteWrEn)
				word_extension_byte <= xbyteWrVal;
		end
	end
endmodule

// *** src/doag_unit.v ***
// One address generator: four pointers, modify and length registers
`timescale 1ns/1ps
`include "doag_defs.vh"
module doag_unit #(
	parameter BITREV_OK = 1
)(
	input  wire                    core_clk,
	input  wire                    reset_n,
	input  wire                    accEn,
	input  wire [`DOAG_SELW-1:0]   accPtr,
	input  wire [`DOAG_SELW-1:0]   accMod,
	input  wire                    bitRevEn,
	input  wire                    ldEn,
	input  wire [1:0]              ldTgt,
	input  wire [`DOAG_SELW-1:0]   ldIdx,
	input  wire [`DOAG_AW-1:0]     ldVal,
	output reg  [`DOAG_AW-1:0]     addrOut,
	output reg                     addrValid
);
	// Each entry lives in its own generate block so every register has a single driver
	wire [`DOAG_AW-1:0] ptrAll  [0:`DOAG_NPTR-1];
	wire [`DOAG_AW-1:0] modAll  [0:`DOAG_NPTR-1];
	wire [`DOAG_AW-1:0] lenAll  [0:`DOAG_NPTR-1];
	wire [`DOAG_AW-1:0] baseAll [0:`DOAG_NPTR-1];
	reg [`DOAG_AW-1:0] cur;
	reg [`DOAG_AW-1:0] rev;
	reg [`DOAG_AW:0]   sum;
	reg [`DOAG_AW:0]   off;
	reg [`DOAG_AW-1:0] ptr_d;
	reg [`DOAG_AW-1:0] modv;
	reg [`DOAG_AW-1:0] lenv;
	integer k;
	always @*
	begin
		cur  = ptrAll[accPtr];
		modv = modAll[accMod];
		lenv = lenAll[accPtr];
		for (k = 0; k < `DOAG_AW; k = k + 1)
			rev[k] = cur[`DOAG_AW-1-k];
		// Modify is two's complement, so the sum wraps naturally
		sum  = {1'b0, cur} + {modv[`DOAG_AW-1], modv};
		off  = {1'b0, cur} + {modv[`DOAG_AW-1], modv} - {1'b0, baseAll[accPtr]};
		ptr_d = sum[`DOAG_AW-1:0];
		if (lenv != {`DOAG_AW{1'b0}})
		begin
			// Offset relative to base; negative means below buffer start
			if (off[`DOAG_AW])
				ptr_d = sum[`DOAG_AW-1:0] + lenv;
			else if (off[`DOAG_AW-1:0] >= lenv)
				ptr_d = sum[`DOAG_AW-1:0] - lenv;
		end
	end
	genvar g;
	generate
		for (g = 0; g < `DOAG_NPTR; g = g + 1)
		begin : gPtr
			reg [`DOAG_AW-1:0] ptr_q;
			reg [`DOAG_AW-1:0] mod_q;
			reg [`DOAG_AW-1:0] len_q;
			reg [`DOAG_AW-1:0] base_q;
			assign ptrAll[g]  = ptr_q;
			assign modAll[g]  = mod_q;
			assign lenAll[g]  = len_q;
			assign baseAll[g] = base_q;
			always @(posedge core_clk)
			begin
				if (!reset_n)
				begin
					ptr_q  <= `DOAG_PTR_RST;
					mod_q  <= `DOAG_PTR_RST;
					len_q  <= `DOAG_PTR_RST;
					base_q <= `DOAG_PTR_RST;
				end
				else
				begin
					// Loads win over a post-modify of the same pointer
					if (ldEn && ldIdx == g && ldTgt == `DOAG_TGT_PTR)
						ptr_q <= ldVal;
					else if (accEn && accPtr == g)
						ptr_q <= ptr_d;
					if (ldEn && ldIdx == g && ldTgt == `DOAG_TGT_MOD)
						mod_q <= ldVal;
					if (ldEn && ldIdx == g && ldTgt == `DOAG_TGT_LEN)
						len_q <= ldVal;
					if (ldEn && ldIdx == g && ldTgt == `DOAG_TGT_BASE)
						base_q <= ldVal;
				end
			end
		end
	endgenerate
	always @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			addrOut   <= `DOAG_PTR_RST;
			addrValid <= 1'b0;
		end
		else
		begin
			addrValid <= accEn;
			if (accEn)
				addrOut <= (BITREV_OK != 0 && bitRevEn) ? rev : cur;
		end
	end
endmodule

// *** testbench/doag_mem_model.sv ***
// Program memory model answering dual-space reads
`timescale 1ns/1ps
module doag_mem_model (
	input wire logic        core_clk,
	input wire logic [13:0] dsAddr,
	input wire logic        dsAddrValid,
	input wire logic        dsIsPm,
	output logic            pmRdData,
	output logic [23:0]     pmRdWord
);
initial {pmRdData, pmRdWord} = 25'h0;
// Word derived from address so the bench can predict it; idle data toggles
always @(posedge core_clk)
begin
	#1;
	pmRdData = dsAddrValid && dsIsPm;
	pmRdWord = pmRdData ? {10'h2a5, dsAddr} : ~pmRdWord;
end
endmodule

// *** testbench/doag_properties.sv ***
// Port assertions for the address generator
`timescale 1ns/1ps
module doag_properties (
	input wire logic        core_clk,
	input wire logic        reset_n,
	input wire logic        dataOnlyAcc,
	input wire logic        dualSpaceAcc,
	input wire logic        dualSpaceToPm,
	input wire logic        sportAcc,
	input wire logic        pmWrReq,
	input wire logic [15:0] pmWrReg,
	input wire logic        pmRdData,
	input wire logic [23:0] pmRdWord,
	input wire logic        sportStall,
	input wire logic [13:0] dmAddr,
	input wire logic        dmAddrValid,
	input wire logic        dsAddrValid,
	input wire logic        dsIsPm,
	input wire logic [23:0] pmWrWord,
	input wire logic        pmWrValid,
	input wire logic [15:0] pmRdReg,
	input wire logic [7:0]  word_extension_byte
);
default clocking @(posedge core_clk); endclocking
default disable iff (!reset_n);
a_dm_issue: assert property (dataOnlyAcc |=> dmAddrValid) else $error("no data address");
a_dm_hold: assert property (!dataOnlyAcc |=> !dmAddrValid && $stable(dmAddr)) else $error("idle address moved");
a_ds_space: assert property (dualSpaceAcc |=> dsAddrValid && dsIsPm == $past(dualSpaceToPm)) else $error("space");
a_ds_idle: assert property (!dualSpaceAcc && !sportAcc |=> !dsAddrValid) else $error("spurious address");
a_sport_stall: assert property (sportStall == (sportAcc && dualSpaceAcc)) else $error("stall wrong");
a_sport_dm: assert property (sportAcc && !dualSpaceAcc |=> dsAddrValid && !dsIsPm) else $error("serial access");
a_pm_pack: assert property (pmWrReq |=> pmWrValid && pmWrWord == {$past(pmWrReg), $past(word_extension_byte)})
	else $error("write word wrong");
a_pm_split: assert property (pmRdData |=> {pmRdReg, word_extension_byte} == $past(pmRdWord))
	else $error("read split wrong");
a_both_issue: assert property (dataOnlyAcc && dualSpaceAcc |=> dmAddrValid && dsAddrValid)
	else $error("units not concurrent");
endmodule
bind doag_top doag_properties u_props (.*);

// *** testbench/tb.sv ***
// Self-checking bench for the address generator
`timescale 1ns/1ps
module tb;
reg core_clk = 0, reset_n = 0, dataOnlyAcc = 0, bitRevMode = 0, dualSpaceAcc = 0, dualSpaceToPm = 0, sportAcc = 0;
reg ldEn = 0, ldUnit = 0, xbyteWrEn = 0, pmWrReq = 0;
reg [1:0] dataOnlyPtr = 0, dataOnlyMod = 0, dualSpacePtr = 0, dualSpaceMod = 0, sportPtr = 0, sportMod = 0;
reg [1:0] ldTgt = 0, ldIdx = 0;
reg [13:0] ldVal = 0;
reg [7:0] xbyteWrVal = 0;
reg [15:0] pmWrReg = 0;
wire pmRdData, sportStall, dmAddrValid, dsAddrValid, dsIsPm, pmWrValid;
wire [23:0] pmRdWord, pmWrWord;
wire [13:0] dmAddr, dsAddr;
wire [15:0] pmRdReg;
wire [7:0] word_extension_byte;
int err_count = 0, comparisons = 0;
doag_top uut (.*);
doag_mem_model mem (.*);
always #20 core_clk = ~core_clk;
task step; @(posedge core_clk); #1; endtask
task chk(input string n, input logic [23:0] e, g);
	comparisons++;
	if (g !== e)
	begin
		err_count++;
		$display("[FAIL] %s expected %h seen %h", n, e, g);
	end
endtask
task wrap_up;
	if (err_count == 0 && comparisons > 0)
		$display("DONE - PASS");
	else
		$display("DONE - FAIL");
	$finish;
endtask
// Caller lowers ldEn after the last load, so no zero-time glitch between loads
task ld(input logic u, input logic [1:0] t, i, input logic [13:0] v);
	{ldEn, ldUnit, ldTgt, ldIdx, ldVal} = {1'b1, u, t, i, v};
	step;
endtask
task t_walk;
	ld(0, 0, 0, 14'h000a);
	ld(0, 1, 0, 14'h0003);
	ld(0, 2, 0, 14'h0008);
	ld(0, 3, 0, 14'h0008);
	ldEn = 0;
	dataOnlyAcc = 1;
	step;
	chk("dmAddr", 14'h000a, dmAddr);
	step;
	chk("dmAddr", 14'h000d, dmAddr);
	step;
	dataOnlyAcc = 0;
	chk("dmAddr", 14'h0008, dmAddr);
endtask
// Buffer [8,12) with modify -3: the step below the base must come back by one length
task t_wrap_down;
	ld(0, 0, 2, 14'h0009);
	ld(0, 1, 2, 14'h3ffd);
	ld(0, 2, 2, 14'h0004);
	ld(0, 3, 2, 14'h0008);
	ldEn = 0;
	{dataOnlyPtr, dataOnlyMod, dataOnlyAcc} = 5'h15;
	step;
	chk("dmAddr", 14'h0009, dmAddr);
	chk("dmAddrValid", 1, dmAddrValid);
	step;
	dataOnlyAcc = 0;
	chk("dmAddr", 14'h000a, dmAddr);
endtask
task t_dual;
	ld(0, 0, 1, 14'h0001);
	ld(1, 0, 0, 14'h0005);
	ld(1, 1, 0, 14'h0001);
	ldEn = 0;
	{dataOnlyPtr, bitRevMode, dataOnlyAcc, dualSpaceAcc, dualSpaceToPm} = 6'h1f;
	step;
	{bitRevMode, dataOnlyAcc, dualSpaceAcc} = 3'h0;
	chk("dmAddr", 14'h2000, dmAddr);
	chk("dsAddr", 14'h0005, dsAddr);
	chk("dsIsPm", 1, dsIsPm);
	step;
	chk("pmRdReg", 16'ha940, pmRdReg);
	chk("extByte", 8'h05, word_extension_byte);
endtask
task t_pmwr;
	{xbyteWrEn, xbyteWrVal} = 9'h15c;
	step;
	{xbyteWrEn, pmWrReq, pmWrReg} = 18'h1beef;
	step;
	pmWrReq = 0;
	chk("pmWrWord", 24'hbeef5c, pmWrWord);
	chk("pmWrValid", 1, pmWrValid);
endtask
task t_sport;
	{sportAcc, dualSpaceAcc, dualSpaceToPm} = 3'h6;
	#1 chk("sportStall", 1, sportStall);
	step;
	dualSpaceAcc = 0;
	chk("dsAddr", 14'h0006, dsAddr);
	step;
	sportAcc = 0;
	chk("dsAddr", 14'h0007, dsAddr);
	chk("dsAddrValid", 1, dsAddrValid);
	chk("dsIsPm", 0, dsIsPm);
endtask
initial
begin
	repeat (3) @(posedge core_clk);
	#1 reset_n = 1;
	t_walk;
	t_wrap_down;
	t_dual;
	t_pmwr;
	t_sport;
	wrap_up;
end
initial
begin
	#5000;
	err_count++;
	wrap_up;
end
endmodule
